// file: fib_top.sv
// Information region, writer link, programming lock and boot wait logic
//
// Contract
// - 256-byte info region: 0x00-0x3F factory data, 0x40-0xFF user OTP.
// - On-chip flash controller may program info region, never erase it.
// - Factory bytes written only in writer mode while main flash erased.
// - User bytes read 0xFF after erase and program only once.
// - Size bytes 0x0C/0x0D: each set bit is one eighth of maximum.
// - Check bytes are XOR of 0x00-0x1E and of 0x20-0x38 group.
// - Probe marker bytes read 0x00 when performed, 0xFF otherwise.
// - Boot segment byte holds last boot instruction MSB, 0xFF if none.
// - Temperature offset LSB first at 0x2B/0x2C, top nibble is delta.
// - Temperature coefficient is unsigned 4.4 fixed point.
// - Wait byte: bits 1-0 add one second, bits 3-2 two seconds each.
// - Bits 7/6 check pads b/a; a low checked pad forces six seconds.
// - Writer mode offers erases, key compare, byte and fast accesses.
// - Writer starts locked; only erases and key compare run.
// - Writer unlocks when compare of 0xFFF8-0xFFFF matches stored key.
// - Each key compare attempt takes ten microseconds.
// - After main erase all bytes read 0xFF; eight 0xFF unlock.
// - Writer port: own clock, data in, data out, busy, low enable.
// - Boot code lives from 0xF000 below key; runs after every reset.
// - Boot scans for programming requests for ten milliseconds.
// - Host session command must arrive in wait time, else run user code.
// - ISP starts locked and unlocks only after 8-byte key match.
`timescale 1ns/1ps
`include "fib_consts.svh"

module fib_top #(
  parameter int unsigned SCAN_CYCLES = `FIB_SCAN_NS / `FIB_CLK_NS,
  parameter int unsigned SEC_CYCLES  = `FIB_SEC_NS / `FIB_CLK_NS
) (
  input  wire logic        REF_CLK_I,
  input  wire logic        RSTN_I,
  input  wire logic        WRITER_CLOCK_IN_I,
  input  wire logic        WRITER_DATA_I,
  input  wire logic        WRITER_ENABLE_N_I,
  output logic             WRITER_DATA_O,
  output logic             WRITER_BUSY_O,
  input  wire logic        BOOT_PAD_CHECK_A_I,
  input  wire logic        BOOT_PAD_CHECK_B_I,
  input  wire logic [2:0]  ISP_PRESENT_I,
  input  wire logic        ISP_REQ_I,
  input  wire logic [7:0]  ISP_OP_I,
  input  wire logic [15:0] ISP_ADDR_I,
  input  wire logic [7:0]  ISP_DATA_I,
  output logic             ISP_DONE_O,
  output logic             ISP_REFUSED_O,
  output logic [7:0]       ISP_RDATA_O,
  input  wire logic        FC_REQ_I,
  input  wire logic [7:0]  FC_OP_I,
  input  wire logic [15:0] FC_ADDR_I,
  input  wire logic [7:0]  FC_DATA_I,
  output logic             FC_DONE_O,
  output logic             FC_REFUSED_O,
  output logic [7:0]       FC_RDATA_O,
  output logic             BOOT_SCANNING_O,
  output logic             BOOT_RUN_USER_O,
  output logic             ISP_SESSION_O,
  output logic             WRITER_UNLOCKED_O,
  output logic             ISP_UNLOCKED_O,
  output logic [3:0]       FLASH_SIZE_O,
  output logic [3:0]       SRAM_SIZE_O,
  output logic             HDR_SUM_OK_O,
  output logic             CAL_SUM_OK_O,
  output logic             PROBE1_DONE_O,
  output logic             PROBE2_DONE_O,
  output logic [7:0]       BOOT_SEGMENT_O,
  output logic [15:0]      TEMP_OFFSET_O,
  output logic [3:0]       TEMP_CAL_DELTA_O,
  output logic [7:0]       TEMP_COEF_O,
  output logic [2:0]       BOOT_WAIT_SEC_O
);
  localparam int unsigned VERIFY_CYCLES = (`FIB_VERIFY_NS + `FIB_CLK_NS - 1) / `FIB_CLK_NS;

  function automatic logic [3:0] ones8(input logic [7:0] b);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 8; i++) n = n + {3'b000, b[i]};
    return n;
  endfunction

  // Nonvolatile arrays, not touched by reset
  logic [7:0] main_mem [0:65535];
  logic [7:0] info_mem [0:`FIB_INFO_BYTES-1];

  // Link domain: shift register framed by the writer enable
  logic [4:0]  lcnt_q;
  logic [31:0] lsh_q;
  logic [31:0] lframe_q;
  logic        ltog_q = 1'b0;
  logic [7:0]  lout_q = 8'h00;
  logic [7:0]  rsp_q;

  always_ff @(posedge WRITER_CLOCK_IN_I or posedge WRITER_ENABLE_N_I)
  begin
    if (WRITER_ENABLE_N_I) lcnt_q <= 5'd0;
    else                   lcnt_q <= lcnt_q + 5'd1;
  end

  always_ff @(posedge WRITER_CLOCK_IN_I)
  begin
    if (!WRITER_ENABLE_N_I)
    begin
      lsh_q  <= {lsh_q[30:0], WRITER_DATA_I};
      lout_q <= (lcnt_q == 5'd0) ? rsp_q : {lout_q[6:0], 1'b0};
      if (lcnt_q == 5'(`FIB_FRAME_BITS - 1))
      begin
        lframe_q <= {lsh_q[30:0], WRITER_DATA_I};
        ltog_q   <= ~ltog_q;
      end
    end
  end

  assign WRITER_DATA_O = lout_q[7];

  // Crossings into the reference domain
  logic tg_s1_q, tg_s2_q, tg_s3_q;
  logic en_s1_q, en_s2_q;
  logic pa_s1_q, pa_s2_q, pb_s1_q, pb_s2_q;

  always_ff @(posedge REF_CLK_I)
  begin
    tg_s1_q <= ltog_q;
    tg_s2_q <= tg_s1_q;
    tg_s3_q <= RSTN_I ? tg_s2_q : tg_s2_q;
    en_s1_q <= WRITER_ENABLE_N_I;
    en_s2_q <= en_s1_q;
    pa_s1_q <= BOOT_PAD_CHECK_A_I;
    pa_s2_q <= pa_s1_q;
    pb_s1_q <= BOOT_PAD_CHECK_B_I;
    pb_s2_q <= pb_s1_q;
  end

  wire frame_new = tg_s2_q ^ tg_s3_q;
  wire wm        = ~en_s2_q;

  // Boot wait time from the wait byte and the pad checks
  wire [7:0] wait_byte = info_mem[`FIB_OFS_WAIT];
  wire       pad_force = (wait_byte[7] & ~pb_s2_q) | (wait_byte[6] & ~pa_s2_q);
  wire [2:0] wait_base = 3'(ones8({6'b000000, wait_byte[1:0]}))
                       + {3'(ones8({6'b000000, wait_byte[3:2]}))} * 3'd2;
  wire [2:0] wait_sec  = pad_force ? `FIB_MAX_WAIT_SEC : wait_base;
  wire [31:0] wait_cyc = 32'(wait_sec) * 32'(SEC_CYCLES);

  // Pending requests from the three sources
  fib_pkg::fib_cmd_t wr_cmd_q, isp_cmd_q, fc_cmd_q, cur;
  fib_pkg::fib_src_t cur_src, src_q;
  fib_pkg::fib_core_t st_q;
  fib_pkg::fib_boot_t boot_q, boot_d;
  logic wr_pend_q, isp_pend_q, fc_pend_q;
  logic [15:0] ecnt_q, eend_q, ptr_q;
  logic        einfo_q, erased_q;
  logic [10:0] hold_q;
  logic [2:0]  vidx_q;
  logic        vok_q, unlk_pend_q, wr_unlk_q, isp_unlk_q;
  logic [31:0] bcnt_q;
  logic        req_seen_q;

  wire go = (st_q == fib_pkg::C_IDLE) && (wr_pend_q | isp_pend_q | fc_pend_q);
  assign cur     = wr_pend_q ? wr_cmd_q : (isp_pend_q ? isp_cmd_q : fc_cmd_q);
  assign cur_src = wr_pend_q ? fib_pkg::SRC_WRITER
                 : (isp_pend_q ? fib_pkg::SRC_ISP : fib_pkg::SRC_FC);

  wire [7:0]  op        = cur.op;
  wire [15:0] fast_ad   = (op == `FIB_OP_FAST_WR || op == `FIB_OP_FAST_RD) ? ptr_q : cur.addr;
  wire [7:0]  info_byte = info_mem[cur.addr[7:0]];
  wire        is_user   = cur.addr[7:0] >= `FIB_USER_BASE;
  wire        otp_ok    = is_user && (info_byte == `FIB_ERASED);
  wire        fac_ok    = (cur_src == fib_pkg::SRC_WRITER) && !is_user && erased_q;
  wire        info_wr_ok = (op != `FIB_OP_WR_INFO) || otp_ok || fac_ok;
  wire        lock_op   = (op == `FIB_OP_MAIN_ERASE) || (op == `FIB_OP_FULL_ERASE)
                       || (op == `FIB_OP_KEY_CMP);
  wire        boot_hit  = (fast_ad >= `FIB_BOOT_BASE) && (fast_ad < `FIB_KEY_BASE);
  wire        main_wr   = (op == `FIB_OP_WR_MAIN) || (op == `FIB_OP_FAST_WR);

  // Legality by source
  wire wr_ok  = wm && (wr_unlk_q || lock_op)
             && (op >= `FIB_OP_MAIN_ERASE) && (op <= `FIB_OP_FAST_RD)
             && info_wr_ok;
  wire isp_ok = (boot_q == fib_pkg::B_WAIT) ? (op == `FIB_OP_HOST)
              : (boot_q == fib_pkg::B_SESSION) && !wm
                && (isp_unlk_q || op == `FIB_OP_KEY_CMP)
                && (op >= `FIB_OP_KEY_CMP) && (op <= `FIB_OP_ERASE_USER)
                && (op != `FIB_OP_HOST) && info_wr_ok
                && !(main_wr && boot_hit);
  wire fc_ok  = !wm && (op >= `FIB_OP_WR_MAIN) && (op <= `FIB_OP_WR_INFO)
             && info_wr_ok;
  wire ok     = (cur_src == fib_pkg::SRC_WRITER) ? wr_ok
              : (cur_src == fib_pkg::SRC_ISP) ? isp_ok : fc_ok;

  // Key compare of one byte
  wire       byte_match = main_mem[cur.addr] == cur.data;
  wire       key_pos    = (cur.addr[15:3] == `FIB_KEY_BASE >> 3) && (cur.addr[2:0] == vidx_q);
  wire       vok_n      = ((vidx_q == 3'd0) || vok_q) && byte_match;
  wire       key_last   = key_pos && (vidx_q == 3'd7);
  wire       do_cmp     = go && ok && (op == `FIB_OP_KEY_CMP);

  // Array write ports
  wire        erasing = st_q == fib_pkg::C_ERASE;
  wire        mw_en   = erasing || (go && ok && main_wr);
  wire [15:0] mw_ad   = erasing ? ecnt_q : fast_ad;
  wire [7:0]  mw_dat  = erasing ? `FIB_ERASED : (main_mem[mw_ad] & cur.data);
  wire        iw_en   = (erasing && einfo_q && ecnt_q[15:8] == 8'h00)
                     || (go && ok && op == `FIB_OP_WR_INFO);
  wire [7:0]  iw_ad   = erasing ? ecnt_q[7:0] : cur.addr[7:0];
  wire [7:0]  iw_dat  = erasing ? `FIB_ERASED : cur.data;

  always_ff @(posedge REF_CLK_I)
  begin
    if (mw_en) main_mem[mw_ad] <= mw_dat;
    if (iw_en) info_mem[iw_ad] <= iw_dat;
  end

  // Completion of a command: immediate, after erase, or after compare hold
  wire imm_done = go && !(ok && (op == `FIB_OP_MAIN_ERASE || op == `FIB_OP_FULL_ERASE
                  || op == `FIB_OP_ERASE_USER || (op == `FIB_OP_KEY_CMP && key_last)));
  wire ers_done = erasing && (ecnt_q == eend_q);
  wire hld_done = (st_q == fib_pkg::C_HOLD) && (hold_q == 11'd0);
  wire fin      = imm_done || ers_done || hld_done;
  wire fin_src_wr  = imm_done ? (cur_src == fib_pkg::SRC_WRITER) : (src_q == fib_pkg::SRC_WRITER);
  wire fin_src_isp = imm_done ? (cur_src == fib_pkg::SRC_ISP) : (src_q == fib_pkg::SRC_ISP);

  logic [7:0] imm_rsp;
  always_comb
  begin
    imm_rsp = `FIB_ST_OK;
    if (!ok) imm_rsp = `FIB_ST_REFUSED;
    else if (op == `FIB_OP_RD_INFO) imm_rsp = info_byte;
    else if (op == `FIB_OP_FAST_RD) imm_rsp = main_mem[ptr_q];
    else if (op == `FIB_OP_KEY_CMP && !byte_match) imm_rsp = `FIB_ST_MISMATCH;
  end
  wire [7:0] fin_rsp = imm_done ? imm_rsp
                     : (hld_done && !vok_q ? `FIB_ST_MISMATCH : `FIB_ST_OK);

  // Capture of requests
  always_ff @(posedge REF_CLK_I)
  begin
    if (!RSTN_I)
    begin
      wr_pend_q  <= 1'b0;
      isp_pend_q <= 1'b0;
      fc_pend_q  <= 1'b0;
      WRITER_BUSY_O <= 1'b0;
    end
    else
    begin
      if (frame_new) wr_cmd_q <= lframe_q;
      if (ISP_REQ_I && !isp_pend_q) isp_cmd_q <= {ISP_OP_I, ISP_ADDR_I, ISP_DATA_I};
      if (FC_REQ_I && !fc_pend_q) fc_cmd_q <= {FC_OP_I, FC_ADDR_I, FC_DATA_I};
      wr_pend_q  <= frame_new | (wr_pend_q & ~(go && cur_src == fib_pkg::SRC_WRITER));
      isp_pend_q <= ISP_REQ_I | (isp_pend_q & ~(go && cur_src == fib_pkg::SRC_ISP));
      fc_pend_q  <= FC_REQ_I | (fc_pend_q & ~(go && cur_src == fib_pkg::SRC_FC));
      WRITER_BUSY_O <= frame_new | (WRITER_BUSY_O & ~(fin && fin_src_wr));
    end
  end

  // Command engine
  always_ff @(posedge REF_CLK_I)
  begin
    if (!RSTN_I)
    begin
      st_q <= fib_pkg::C_IDLE;
      src_q <= fib_pkg::SRC_WRITER;
      ecnt_q <= 16'h0000;
      eend_q <= 16'h0000;
      einfo_q <= 1'b0;
      erased_q <= 1'b0;
      ptr_q <= 16'h0000;
      hold_q <= 11'd0;
      vidx_q <= 3'd0;
      vok_q <= 1'b0;
      unlk_pend_q <= 1'b0;
      wr_unlk_q <= 1'b0;
      isp_unlk_q <= 1'b0;
      rsp_q <= `FIB_ST_OK;
      ISP_DONE_O <= 1'b0;
      ISP_REFUSED_O <= 1'b0;
      ISP_RDATA_O <= 8'h00;
      FC_DONE_O <= 1'b0;
      FC_REFUSED_O <= 1'b0;
      FC_RDATA_O <= 8'h00;
    end
    else
    begin
      ISP_DONE_O <= fin && fin_src_isp;
      FC_DONE_O  <= fin && !fin_src_wr && !fin_src_isp;
      ISP_REFUSED_O <= fin && fin_src_isp && fin_rsp == `FIB_ST_REFUSED && imm_done;
      FC_REFUSED_O  <= fin && !fin_src_wr && !fin_src_isp && fin_rsp == `FIB_ST_REFUSED;
      if (fin && fin_src_wr) rsp_q <= fin_rsp;
      if (fin && fin_src_isp) ISP_RDATA_O <= fin_rsp;
      if (fin && !fin_src_wr && !fin_src_isp) FC_RDATA_O <= fin_rsp;
      case (st_q)
        fib_pkg::C_IDLE:
        begin
          if (go && ok)
          begin
            src_q <= cur_src;
            if (op == `FIB_OP_MAIN_ERASE || op == `FIB_OP_FULL_ERASE
                || op == `FIB_OP_ERASE_USER)
            begin
              st_q <= fib_pkg::C_ERASE;
              ecnt_q <= 16'h0000;
              eend_q <= (op == `FIB_OP_ERASE_USER) ? `FIB_BOOT_BASE - 16'h0001
                                                   : `FIB_MAIN_LAST;
              einfo_q <= op == `FIB_OP_FULL_ERASE;
            end
            if (main_wr) erased_q <= 1'b0;
            if (main_wr || op == `FIB_OP_FAST_RD) ptr_q <= fast_ad + 16'h0001;
            if (do_cmp)
            begin
              vidx_q <= key_pos ? vidx_q + 3'd1 : 3'd0;
              vok_q <= vok_n;
              if (key_last)
              begin
                st_q <= fib_pkg::C_HOLD;
                hold_q <= 11'(VERIFY_CYCLES - 1);
                unlk_pend_q <= vok_n;
              end
            end
          end
        end
        fib_pkg::C_ERASE:
        begin
          ecnt_q <= ecnt_q + 16'h0001;
          if (ers_done)
          begin
            st_q <= fib_pkg::C_IDLE;
            erased_q <= eend_q == `FIB_MAIN_LAST;
          end
        end
        fib_pkg::C_HOLD:
        begin
          hold_q <= hold_q - 11'd1;
          if (hld_done)
          begin
            st_q <= fib_pkg::C_IDLE;
            if (unlk_pend_q && src_q == fib_pkg::SRC_WRITER) wr_unlk_q <= 1'b1;
            if (unlk_pend_q && src_q == fib_pkg::SRC_ISP) isp_unlk_q <= 1'b1;
          end
        end
        default: st_q <= fib_pkg::C_IDLE;
      endcase
    end
  end

  // Boot sequencer, restarted by every reset
  wire host_ok = go && ok && cur_src == fib_pkg::SRC_ISP && op == `FIB_OP_HOST;
  always_comb
  begin
    boot_d = boot_q;
    case (boot_q)
      fib_pkg::B_SCAN:
        if (bcnt_q >= SCAN_CYCLES - 1)
          boot_d = (req_seen_q || ISP_PRESENT_I != 3'b000) ? fib_pkg::B_WAIT : fib_pkg::B_USER;
      fib_pkg::B_WAIT:
        if (host_ok) boot_d = fib_pkg::B_SESSION;
        else if (bcnt_q >= wait_cyc) boot_d = fib_pkg::B_USER;
      default: boot_d = boot_q;
    endcase
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (!RSTN_I)
    begin
      boot_q <= fib_pkg::B_SCAN;
      bcnt_q <= 32'd0;
      req_seen_q <= 1'b0;
      BOOT_SCANNING_O <= 1'b1;
      BOOT_RUN_USER_O <= 1'b0;
      ISP_SESSION_O <= 1'b0;
    end
    else
    begin
      boot_q <= boot_d;
      bcnt_q <= (boot_d != boot_q) ? 32'd0 : bcnt_q + 32'd1;
      req_seen_q <= req_seen_q | (ISP_PRESENT_I != 3'b000);
      BOOT_SCANNING_O <= boot_d == fib_pkg::B_SCAN;
      BOOT_RUN_USER_O <= boot_d == fib_pkg::B_USER;
      ISP_SESSION_O <= boot_d == fib_pkg::B_SESSION;
    end
  end

  // Decoded fields of the information region
  logic [7:0] hdr_x, cal_x;
  always_comb
  begin
    hdr_x = 8'h00;
    cal_x = 8'h00;
    for (int i = 0; i < 31; i++) hdr_x = hdr_x ^ info_mem[i];
    for (int i = 32; i < 57; i++) cal_x = cal_x ^ info_mem[i];
  end

  always_ff @(posedge REF_CLK_I)
  begin
    WRITER_UNLOCKED_O <= RSTN_I & wr_unlk_q;
    ISP_UNLOCKED_O    <= RSTN_I & isp_unlk_q;
    FLASH_SIZE_O   <= ones8(info_mem[`FIB_OFS_FLASH_SIZE]);
    SRAM_SIZE_O    <= ones8(info_mem[`FIB_OFS_SRAM_SIZE]);
    HDR_SUM_OK_O   <= hdr_x == info_mem[`FIB_OFS_HDR_SUM];
    CAL_SUM_OK_O   <= cal_x == info_mem[`FIB_OFS_CAL_SUM];
    PROBE1_DONE_O  <= info_mem[`FIB_OFS_PROBE1] == `FIB_PROBE_DONE;
    PROBE2_DONE_O  <= info_mem[`FIB_OFS_PROBE2] == `FIB_PROBE_DONE;
    BOOT_SEGMENT_O <= info_mem[`FIB_OFS_BOOT_SEG];
    TEMP_OFFSET_O  <= {info_mem[`FIB_OFS_TOFS_HI], info_mem[`FIB_OFS_TOFS_LO]};
    TEMP_CAL_DELTA_O <= info_mem[`FIB_OFS_TOFS_HI][7:4];
    TEMP_COEF_O    <= info_mem[`FIB_OFS_TCOEF];
    BOOT_WAIT_SEC_O <= wait_sec;
  end
endmodule // fib_top

// file: fib_consts.svh
// Constants of the information region, writer link and boot sequencer
`ifndef FIB_CONSTS_SVH
`define FIB_CONSTS_SVH
`define FIB_INFO_BYTES     256
`define FIB_USER_BASE      8'h40
`define FIB_OFS_FLASH_SIZE 8'h0c
`define FIB_OFS_SRAM_SIZE  8'h0d
`define FIB_OFS_PROBE1     8'h10
`define FIB_OFS_PROBE2     8'h11
`define FIB_OFS_BOOT_SEG   8'h1e
`define FIB_OFS_HDR_SUM    8'h1f
`define FIB_OFS_CAL_BASE   8'h20
`define FIB_OFS_CAL_SUM    8'h39
`define FIB_OFS_TOFS_LO    8'h2b
`define FIB_OFS_TOFS_HI    8'h2c
`define FIB_OFS_TCOEF      8'h2d
`define FIB_OFS_WAIT       8'h40
`define FIB_ERASED         8'hff
`define FIB_PROBE_DONE     8'h00
`define FIB_KEY_BASE       16'hfff8
`define FIB_BOOT_BASE      16'hf000
`define FIB_MAIN_LAST      16'hffff
`define FIB_MAX_WAIT_SEC   3'd6
`define FIB_OP_MAIN_ERASE  8'h01
`define FIB_OP_FULL_ERASE  8'h02
`define FIB_OP_KEY_CMP     8'h03
`define FIB_OP_WR_MAIN     8'h04
`define FIB_OP_RD_INFO     8'h05
`define FIB_OP_WR_INFO     8'h06
`define FIB_OP_FAST_WR     8'h07
`define FIB_OP_FAST_RD     8'h08
`define FIB_OP_HOST        8'h09
`define FIB_OP_ERASE_USER  8'h0a
`define FIB_ST_OK          8'h00
`define FIB_ST_MISMATCH    8'h01
`define FIB_ST_REFUSED     8'he1
`define FIB_FRAME_BITS     32
`define FIB_CLK_NS         8
`define FIB_VERIFY_NS      10000
`define FIB_SCAN_NS        10000000
`define FIB_SEC_NS         1000000000
`endif

// file: fib_pkg.sv
// Types shared by the information region and programming lock block
package fib_pkg;
  typedef enum logic [1:0] {SRC_WRITER, SRC_ISP, SRC_FC} fib_src_t;
  typedef enum logic [1:0] {C_IDLE, C_ERASE, C_HOLD} fib_core_t;
  typedef enum logic [1:0] {B_SCAN, B_WAIT, B_SESSION, B_USER} fib_boot_t;
  typedef struct packed {
    logic [7:0]  op;
    logic [15:0] addr;
    logic [7:0]  data;
  } fib_cmd_t;
endpackage

// file: fib_top_asserts.sv
// Port checker for the information region lock and boot sequencer
`timescale 1ns/1ps
module fib_top_asserts #(
  parameter int unsigned SCAN_CYCLES = 50,
  parameter int unsigned SEC_CYCLES  = 20
) (
  input wire logic        REF_CLK_I,
  input wire logic        RSTN_I,
  input wire logic        WRITER_BUSY_O,
  input wire logic [2:0]  ISP_PRESENT_I,
  input wire logic        ISP_REQ_I,
  input wire logic [7:0]  ISP_OP_I,
  input wire logic        ISP_DONE_O,
  input wire logic        ISP_REFUSED_O,
  input wire logic        ISP_SESSION_O,
  input wire logic        ISP_UNLOCKED_O,
  input wire logic        FC_REQ_I,
  input wire logic [7:0]  FC_OP_I,
  input wire logic        FC_DONE_O,
  input wire logic        FC_REFUSED_O,
  input wire logic        BOOT_SCANNING_O,
  input wire logic        BOOT_RUN_USER_O,
  input wire logic        WRITER_UNLOCKED_O,
  input wire logic [15:0] TEMP_OFFSET_O,
  input wire logic [3:0]  TEMP_CAL_DELTA_O,
  input wire logic [2:0]  BOOT_WAIT_SEC_O
);
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RSTN_I);
  logic [31:0] scan_q;
  logic [31:0] wait_q;
  wire         waiting = RSTN_I && !BOOT_SCANNING_O && !BOOT_RUN_USER_O && !ISP_SESSION_O;
  always_ff @(posedge REF_CLK_I)
  begin
    scan_q <= RSTN_I ? scan_q + 32'(BOOT_SCANNING_O) : 32'h0;
    wait_q <= waiting ? wait_q + 32'h1 : 32'h0;
  end
  property p_rst_locked;
    !$past(RSTN_I) |-> BOOT_SCANNING_O && !WRITER_UNLOCKED_O && !ISP_UNLOCKED_O;
  endproperty
  a_rst_locked: assert property (p_rst_locked) else $error("lock or boot state after reset");
  property p_scan_len;
    $fell(BOOT_SCANNING_O) |-> scan_q + 3 >= SCAN_CYCLES && scan_q <= SCAN_CYCLES + 3;
  endproperty
  a_scan_len: assert property (p_scan_len) else $error("scan length wrong");
  property p_no_req_user;
    $fell(BOOT_SCANNING_O) && ISP_PRESENT_I == 3'h0 |-> ##[0:2] BOOT_RUN_USER_O;
  endproperty
  a_no_req_user: assert property (p_no_req_user) else $error("user code not started");
  property p_wait_bound;
    wait_q > 32'd3 |-> wait_q <= 32'(BOOT_WAIT_SEC_O) * SEC_CYCLES + 32'd3;
  endproperty
  a_wait_bound: assert property (p_wait_bound) else $error("boot wait too long");
  property p_user_excl;
    BOOT_RUN_USER_O |-> !ISP_SESSION_O && !BOOT_SCANNING_O;
  endproperty
  a_user_excl: assert property (p_user_excl) else $error("user code with session");
  property p_fc_erase;
    FC_REQ_I && (FC_OP_I == 8'h01 || FC_OP_I == 8'h02) && !WRITER_BUSY_O
      |-> ##[2:3] FC_DONE_O && FC_REFUSED_O;
  endproperty
  a_fc_erase: assert property (p_fc_erase) else $error("controller erase accepted");
  property p_isp_locked;
    ISP_REQ_I && ISP_SESSION_O && !ISP_UNLOCKED_O && ISP_OP_I != 8'h03 && !WRITER_BUSY_O
      |-> ##[2:3] ISP_DONE_O && ISP_REFUSED_O;
  endproperty
  a_isp_locked: assert property (p_isp_locked) else $error("locked isp accepted");
  property p_unlock_cause;
    $rose(WRITER_UNLOCKED_O) |-> $past(WRITER_BUSY_O, 3);
  endproperty
  a_unlock_cause: assert property (p_unlock_cause) else $error("unlock without compare");
  property p_sticky;
    WRITER_UNLOCKED_O |=> WRITER_UNLOCKED_O;
  endproperty
  a_sticky: assert property (p_sticky) else $error("writer relocked without reset");
  property p_temp;
    WRITER_UNLOCKED_O || ISP_UNLOCKED_O |-> TEMP_CAL_DELTA_O == TEMP_OFFSET_O[15:12];
  endproperty
  a_temp: assert property (p_temp) else $error("temperature delta mismatch");
  c_session: cover property ($rose(ISP_SESSION_O));
  c_user: cover property ($rose(BOOT_RUN_USER_O));
  c_unlock: cover property ($rose(WRITER_UNLOCKED_O));
endmodule // fib_top_asserts
bind fib_top fib_top_asserts #(.SCAN_CYCLES(SCAN_CYCLES), .SEC_CYCLES(SEC_CYCLES)) u_chk (.*);

// file: fib_writer_model.sv
// Serial programming station model for the writer link
`timescale 1ns/1ps
module fib_writer_model (
  input  wire logic ref_clk_i,
  input  wire logic busy_i,
  input  wire logic tdo_i,
  output logic      clk_o,
  output logic      tdi_o,
  output logic      en_n_o,
  output logic [7:0] resp_o,
  output int        busy_n_o
);
  int gap_ns = 0;
  initial
  begin
    clk_o = 1'b0;
    tdi_o = 1'b0;
    en_n_o = 1'b1;
    resp_o = 8'h00;
    busy_n_o = 0;
  end
  // Sends one frame MSB first, clock runs only inside it
  task automatic frame(input logic [31:0] word);
    int n;
    #(gap_ns + 3);
    en_n_o = 1'b0;
    for (int i = 31; i >= 0; i--)
    begin
      tdi_o = word[i];
      #40 clk_o = 1'b1;
      #40 clk_o = 1'b0;
      if (i >= 24)
        resp_o[i - 24] = tdo_i;
    end
    tdi_o = ~tdi_o;
    n = 0;
    while (busy_i !== 1'b1 && n < 20)
    begin
      @(posedge ref_clk_i);
      n++;
    end
    busy_n_o = 0;
    while (busy_i === 1'b1 && busy_n_o < 70000)
    begin
      @(posedge ref_clk_i);
      busy_n_o++;
    end
    en_n_o = 1'b1;
  endtask
endmodule // fib_writer_model

// file: test_flash_info_block_program_lock.sv
// Self-checking bench for the information region lock and boot sequencer
`timescale 1ns/1ps
module test_flash_info_block_program_lock;
  localparam int unsigned SCAN = 50;
  localparam int unsigned SEC = 20;
  logic REF_CLK_I = 1'b0, RSTN_I = 1'b0, ISP_REQ_I = 1'b0, FC_REQ_I = 1'b0;
  logic BOOT_PAD_CHECK_A_I = 1'b1, BOOT_PAD_CHECK_B_I = 1'b1;
  logic [2:0] ISP_PRESENT_I = 3'h0;
  logic [7:0] ISP_OP_I = 8'h0, ISP_DATA_I = 8'h0, FC_OP_I = 8'h0, FC_DATA_I = 8'h0;
  logic [15:0] ISP_ADDR_I = 16'h0, FC_ADDR_I = 16'h0;
  logic WRITER_CLOCK_IN_I, WRITER_DATA_I, WRITER_ENABLE_N_I, WRITER_DATA_O, WRITER_BUSY_O;
  logic ISP_DONE_O, ISP_REFUSED_O, FC_DONE_O, FC_REFUSED_O, BOOT_SCANNING_O, BOOT_RUN_USER_O;
  logic ISP_SESSION_O, WRITER_UNLOCKED_O, ISP_UNLOCKED_O, HDR_SUM_OK_O, CAL_SUM_OK_O, rf;
  logic PROBE1_DONE_O, PROBE2_DONE_O;
  logic [7:0] ISP_RDATA_O, FC_RDATA_O, BOOT_SEGMENT_O, TEMP_COEF_O, resp, rd;
  logic [3:0] FLASH_SIZE_O, SRAM_SIZE_O, TEMP_CAL_DELTA_O;
  logic [15:0] TEMP_OFFSET_O;
  logic [2:0] BOOT_WAIT_SEC_O;
  int n_errors = 0, checks = 0, busy_n, n;
  always #4 REF_CLK_I = ~REF_CLK_I;
  fib_top #(.SCAN_CYCLES(SCAN), .SEC_CYCLES(SEC)) uut (.*);
  fib_writer_model wm (.ref_clk_i(REF_CLK_I), .busy_i(WRITER_BUSY_O), .tdo_i(WRITER_DATA_O),
    .clk_o(WRITER_CLOCK_IN_I), .tdi_o(WRITER_DATA_I), .en_n_o(WRITER_ENABLE_N_I),
    .resp_o(resp), .busy_n_o(busy_n));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wait_for(ref logic s, input int lim);
    n = 0;
    while (s !== 1'b1 && n < lim)
    begin
      @(negedge REF_CLK_I);
      n++;
    end
  endtask
  task automatic do_reset(input logic [2:0] pres);
    @(negedge REF_CLK_I);
    RSTN_I = 1'b0;
    ISP_PRESENT_I = pres;
    repeat (3) @(negedge REF_CLK_I);
    chk(BOOT_SCANNING_O, 1'b1);
    chk(WRITER_UNLOCKED_O, 1'b0);
    RSTN_I = 1'b1;
  endtask
  task automatic bus(input bit isp, input logic [7:0] op, input logic [15:0] a, input logic [7:0] d);
    @(negedge REF_CLK_I);
    {ISP_REQ_I, ISP_OP_I, ISP_ADDR_I, ISP_DATA_I} = {isp, op, a, d};
    {FC_REQ_I, FC_OP_I, FC_ADDR_I, FC_DATA_I} = {!isp, op, a, d};
    @(negedge REF_CLK_I);
    ISP_REQ_I = 1'b0;
    FC_REQ_I = 1'b0;
    if (isp) wait_for(ISP_DONE_O, 3000);
    else wait_for(FC_DONE_O, 3000);
    rd = isp ? ISP_RDATA_O : FC_RDATA_O;
    rf = isp ? ISP_REFUSED_O : FC_REFUSED_O;
  endtask
  task automatic t_locked;
    wm.frame(32'h05004100);
    wm.frame(32'h05004100);
    chk(resp, 8'he1);
    bus(1'b0, 8'h01, 16'h0, 8'h0);
    chk(rf, 1'b1);
  endtask
  task automatic t_erase;
    wm.frame(32'h02000000);
    repeat (4) @(negedge REF_CLK_I);
    chk(FLASH_SIZE_O, 4'h8);
    chk({PROBE1_DONE_O, PROBE2_DONE_O}, 2'h0);
    chk(BOOT_SEGMENT_O, 8'hff);
    chk({HDR_SUM_OK_O, CAL_SUM_OK_O}, 2'h3);
    chk(TEMP_OFFSET_O, 16'hffff);
    chk(TEMP_COEF_O, 8'hff);
    chk(BOOT_WAIT_SEC_O, 3'h6);
    for (int i = 0; i < 8; i++)
    begin
      wm.frame({8'h03, 16'hfff8 + 16'(i), 8'hff});
      chk(resp, 8'h00);
    end
    chk(busy_n >= 1250, 1'b1);
    repeat (2) @(negedge REF_CLK_I);
    chk(WRITER_UNLOCKED_O, 1'b1);
  endtask
  task automatic t_info;
    logic [31:0] cmd [10];
    logic [7:0] ex [10];
    cmd = '{32'h06004085, 32'h06000c0f, 32'h06004000, 32'h0400ff3c, 32'h070000a5,
            32'h0400ffff, 32'h08000000, 32'h06000d0f, 32'h05004000, 32'h05000c00};
    ex = '{8'h00, 8'h00, 8'he1, 8'h00, 8'h00, 8'h00, 8'ha5, 8'he1, 8'h85, 8'h0f};
    wm.gap_ns = 500;
    for (int k = 0; k <= 10; k++)
    begin
      wm.frame(k < 10 ? cmd[k] : 32'h05000d00);
      if (k > 0) chk(resp, ex[k - 1]);
    end
    chk(BOOT_WAIT_SEC_O, 3'h3);
    chk(FLASH_SIZE_O, 4'h4);
    chk(SRAM_SIZE_O, 4'h8);
  endtask
  task automatic t_fc;
    bus(1'b0, 8'h05, 16'h0041, 8'h00);
    chk(rd, 8'hff);
    bus(1'b0, 8'h06, 16'h0041, 8'h3c);
    chk({rf, rd}, 9'h000);
    bus(1'b0, 8'h05, 16'h0041, 8'h00);
    chk(rd, 8'h3c);
    bus(1'b0, 8'h02, 16'h0, 8'h0);
    chk(rf, 1'b1);
  endtask
  task automatic t_isp;
    do_reset(3'h1);
    repeat (SCAN + 4) @(negedge REF_CLK_I);
    bus(1'b1, 8'h09, 16'h0, 8'h0);
    chk(ISP_SESSION_O, 1'b1);
    bus(1'b1, 8'h05, 16'h0040, 8'h0);
    chk(rf, 1'b1);
    for (int j = 0; j < 16; j++)
      bus(1'b1, 8'h03, 16'hfff8 + 16'(j % 8), j == 7 ? 8'hfe : 8'hff);
    chk(rd, 8'h00);
    wait_for(ISP_UNLOCKED_O, 1400);
    chk(ISP_UNLOCKED_O, 1'b1);
    bus(1'b1, 8'h05, 16'h0040, 8'h0);
    chk({rf, rd}, 9'h085);
  endtask
  initial
  begin
    do_reset(3'h0);
    wait_for(BOOT_RUN_USER_O, SCAN + 20);
    chk(n + 4 >= SCAN && n <= SCAN + 4, 1'b1);
    t_locked;
    t_erase;
    t_info;
    t_fc;
    t_isp;
    @(negedge REF_CLK_I);
    BOOT_PAD_CHECK_B_I = 1'b0;
    do_reset(3'h2);
    wait_for(BOOT_RUN_USER_O, SCAN + 200);
    chk(n + 5 >= SCAN + 6 * SEC && n <= SCAN + 6 * SEC + 5, 1'b1);
    chk(BOOT_WAIT_SEC_O, 3'h6);
    final_report;
  end
  initial
  begin
    #800000;
    n_errors++;
    final_report;
  end
endmodule // test_flash_info_block_program_lock
